// ==== hdl/icmc_core.sv ====
`timescale 1ns/10ps
module icmc_core #(
  parameter int RATE_LO_CYCLES = icmc_pkg::RATE_LO_CYC,
  parameter int BIT_CYCLES = icmc_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic err_cnt_en,
  input wire logic coarse_align,
  input wire logic cage_switch,
  input wire logic cnt_zero,
  input wire logic torque_en,
  input wire logic [1:0] gyro_sel,
  input wire logic gyro_neg,
  input wire logic torque_set,
  input wire logic [2:0] cmd_up,
  input wire logic [2:0] cmd_dn,
  input wire logic [2:0] gimbal_up,
  input wire logic [2:0] gimbal_dn,
  output logic [2:0] angle_up,
  output logic [2:0] angle_dn,
  output logic [2:0][icmc_pkg::ERR_W-1:0] err_drive,
  output logic drive_from_err,
  output logic torque_path,
  output logic [2:0] torque_on,
  output logic torque_neg,
  output logic cage_drive,
  output logic coarse_relay,
  output logic no_attitude_lamp,
  output icmc_pkg::icmc_mode_t mode,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int EW = icmc_pkg::ERR_W;
  localparam int PW = icmc_pkg::PEND_W;
  localparam int ERR_MAX = 2 ** (EW - 1) - 1;
  localparam logic [icmc_pkg::DIV_W-1:0] HI_RELOAD = icmc_pkg::DIV_W'(icmc_pkg::RATE_HI_CYC - 1);
  localparam logic [icmc_pkg::DIV_W-1:0] LO_RELOAD = icmc_pkg::DIV_W'(RATE_LO_CYCLES - 1);
  localparam logic [icmc_pkg::TQ_W-1:0] TQ_STEP = icmc_pkg::TQ_W'(BIT_CYCLES);

  // Saturating add keeps a runaway burst from wrapping sign
  function automatic logic signed [EW-1:0] sat_add(input logic signed [EW-1:0] a, input logic signed [2:0] d);
    logic signed [EW+1:0] s;
    s = (EW+2)'(a) + (EW+2)'(d);
    // Limits are signed so a negative sum is not read as a huge positive one
    if (s > (EW+2)'(ERR_MAX)) begin
      sat_add = EW'(ERR_MAX);
    end else if (s < -(EW+2)'(ERR_MAX)) begin
      sat_add = -EW'(ERR_MAX);
    end else begin
      sat_add = s[EW-1:0];
    end
  endfunction : sat_add

  // ***********************************************
  // Mode decode
  // ***********************************************
  icmc_pkg::icmc_mode_t next_mode;
  logic next_cage_drive, next_coarse_relay, next_drive_from_err, next_torque_path, next_lamp;

  // Cage wins over every computer discrete
  always_comb begin
    if (cage_switch) begin
      next_mode = icmc_pkg::ICMC_CAGE;
    end else if (err_cnt_en && coarse_align) begin
      next_mode = icmc_pkg::ICMC_COARSE;
    end else if (err_cnt_en) begin
      next_mode = icmc_pkg::ICMC_DISPLAY;
    end else if (coarse_align) begin
      next_mode = icmc_pkg::ICMC_TURN_ON;
    end else if (torque_en) begin
      next_mode = icmc_pkg::ICMC_FINE;
    end else begin
      next_mode = icmc_pkg::ICMC_INERTIAL;
    end
    next_cage_drive = cage_switch;
    next_coarse_relay = cage_switch || coarse_align;
    next_drive_from_err = next_mode == icmc_pkg::ICMC_COARSE;
    next_torque_path = torque_en && !next_coarse_relay;
    next_lamp = cage_switch;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= icmc_pkg::ICMC_INERTIAL;
      cage_drive <= 1'b0;
      coarse_relay <= 1'b0;
      drive_from_err <= 1'b0;
      torque_path <= 1'b0;
      no_attitude_lamp <= 1'b0;
    end else begin
      mode <= next_mode;
      cage_drive <= next_cage_drive;
      coarse_relay <= next_coarse_relay;
      drive_from_err <= next_drive_from_err;
      torque_path <= next_torque_path;
      no_attitude_lamp <= next_lamp;
    end
  end

  // ***********************************************
  // Rate divider and counters
  // ***********************************************
  logic rate_lo;
  logic [icmc_pkg::DIV_W-1:0] div_q, next_div;
  logic signed [2:0][PW-1:0] pend_q, next_pend;
  logic signed [2:0][icmc_pkg::RD_W-1:0] rd_q, next_rd;
  logic signed [2:0][EW-1:0] next_err;
  logic [2:0] next_up, next_dn;
  logic step_ok, fb_on, err_on;

  // Stepping is paced only in coarse align; elsewhere one step per clock
  always_comb begin
    logic signed [2:0] d;
    d = 3'sh0;
    step_ok = (mode != icmc_pkg::ICMC_COARSE) || (div_q == '0);
    next_div = (div_q == '0) ? (rate_lo ? LO_RELOAD : HI_RELOAD) : div_q - 1'b1;
    fb_on = mode == icmc_pkg::ICMC_COARSE;
    err_on = fb_on || mode == icmc_pkg::ICMC_DISPLAY;
    for (int i = 0; i < icmc_pkg::AXES; i++) begin
      next_pend[i] = pend_q[i] + PW'($signed({1'b0, gimbal_up[i]})) - PW'($signed({1'b0, gimbal_dn[i]}));
      next_up[i] = 1'b0;
      next_dn[i] = 1'b0;
      next_rd[i] = rd_q[i];
      if (cnt_zero) begin
        next_pend[i] = '0;
        next_rd[i] = '0;
      end else if (step_ok && $signed(pend_q[i]) > 0) begin
        next_up[i] = 1'b1;
        next_pend[i] = next_pend[i] - 1'b1;
        next_rd[i] = rd_q[i] + 1'b1;
      end else if (step_ok && $signed(pend_q[i]) < 0) begin
        next_dn[i] = 1'b1;
        next_pend[i] = next_pend[i] + 1'b1;
        next_rd[i] = rd_q[i] - 1'b1;
      end
      d = 3'($signed({2'b00, cmd_up[i]})) - 3'($signed({2'b00, cmd_dn[i]}));
      if (fb_on) begin
        d = d - 3'($signed({2'b00, next_up[i]})) + 3'($signed({2'b00, next_dn[i]}));
      end
      next_err[i] = err_on ? sat_add(err_drive[i], d) : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
      pend_q <= '0;
      rd_q <= '0;
      err_drive <= '0;
      angle_up <= '0;
      angle_dn <= '0;
    end else begin
      div_q <= next_div;
      pend_q <= next_pend;
      rd_q <= next_rd;
      err_drive <= next_err;
      angle_up <= next_up;
      angle_dn <= next_dn;
    end
  end

  // ***********************************************
  // Gyro torque timing
  // ***********************************************
  logic [icmc_pkg::TQ_W-1:0] tq_q, next_tq;
  logic [2:0] next_on;
  logic next_neg;

  // Each set pulse buys one bit period of constant current
  always_comb begin
    next_tq = (tq_q != '0) ? tq_q - 1'b1 : tq_q;
    if (!torque_path) begin
      next_tq = '0;
    end else if (torque_set && tq_q <= ~TQ_STEP) begin
      next_tq = next_tq + TQ_STEP;
    end
    next_on = '0;
    if (next_tq != '0 && gyro_sel < 2'h3) begin
      next_on[gyro_sel] = 1'b1;
    end
    next_neg = gyro_neg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tq_q <= '0;
      torque_on <= '0;
      torque_neg <= 1'b0;
    end else begin
      tq_q <= next_tq;
      torque_on <= next_on;
      torque_neg <= next_neg;
    end
  end

  // ***********************************************
  // Avalon slave, one wait state per access
  // ***********************************************
  logic next_wait, next_rate_lo;
  logic [31:0] next_rdata;

  // All eight words are mapped and read back; writes to any word but control are dropped
  always_comb begin
    next_wait = !((avs_read || avs_write) && avs_waitrequest);
    next_rate_lo = rate_lo;
    if (avs_write && !avs_waitrequest && avs_address == icmc_pkg::REG_CTRL) begin
      next_rate_lo = avs_writedata[icmc_pkg::CTRL_RATE_LO_BIT];
    end
    next_rdata = '0;
    if (avs_address == icmc_pkg::REG_CTRL) begin
      next_rdata = 32'(rate_lo);
    end else if (avs_address == icmc_pkg::REG_STATUS) begin
      next_rdata = {26'h0, no_attitude_lamp, torque_path, 1'b0, mode};
    end else if (avs_address < icmc_pkg::REG_READ0) begin
      next_rdata = 32'($signed(err_drive[2'(avs_address - icmc_pkg::REG_ERR0)]));
    end else begin
      next_rdata = 32'($signed(rd_q[2'(avs_address - icmc_pkg::REG_READ0)]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      rate_lo <= icmc_pkg::CTRL_RESET;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
      rate_lo <= next_rate_lo;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  property p_coarse;
    @(posedge clk) disable iff (rst) (err_cnt_en && coarse_align && !cage_switch) |=> mode == icmc_pkg::ICMC_COARSE;
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse not entered");
  property p_route;
    @(posedge clk) disable iff (rst) mode == icmc_pkg::ICMC_COARSE |-> drive_from_err && !torque_path;
  endproperty
  a_route: assert property (p_route) else $error("coarse routing wrong");
  property p_report;
    @(posedge clk) disable iff (rst) (mode == icmc_pkg::ICMC_INERTIAL && $signed(pend_q[0]) > 0 && !cnt_zero)
      |=> angle_up[0];
  endproperty
  a_report: assert property (p_report) else $error("step not reported");
  property p_fb;
    @(posedge clk) disable iff (rst) (mode == icmc_pkg::ICMC_COARSE && next_up[1] && !cmd_up[1] && !cmd_dn[1]
      && $signed(err_drive[1]) > 0) |=> err_drive[1] == $past(err_drive[1]) - 1;
  endproperty
  a_fb: assert property (p_fb) else $error("feedback not applied");
  property p_pace;
    @(posedge clk) disable iff (rst) (mode == icmc_pkg::ICMC_COARSE && div_q != '0) |-> next_up == '0 && next_dn == '0;
  endproperty
  a_pace: assert property (p_pace) else $error("step between rate ticks");
  property p_inertial;
    @(posedge clk) disable iff (rst) !(err_cnt_en || coarse_align || cage_switch || torque_en)
      |=> mode == icmc_pkg::ICMC_INERTIAL;
  endproperty
  a_inertial: assert property (p_inertial) else $error("default mode wrong");
  property p_fine;
    @(posedge clk) disable iff (rst) mode == icmc_pkg::ICMC_FINE |=> err_drive[2] == '0;
  endproperty
  a_fine: assert property (p_fine) else $error("error counter live in fine align");
  property p_display;
    @(posedge clk) disable iff (rst) (mode == icmc_pkg::ICMC_DISPLAY && !cmd_up[0] && !cmd_dn[0]
      && next_mode == icmc_pkg::ICMC_DISPLAY) |=> $stable(err_drive[0]);
  endproperty
  a_display: assert property (p_display) else $error("feedback in display mode");
  property p_cage;
    @(posedge clk) disable iff (rst) cage_switch |=> cage_drive && coarse_relay && no_attitude_lamp;
  endproperty
  a_cage: assert property (p_cage) else $error("cage paths off");
  property p_zero;
    @(posedge clk) disable iff (rst) cnt_zero |=> rd_q[0] == '0 && angle_up == '0 && angle_dn == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero discrete ignored");
  property p_torque;
    @(posedge clk) disable iff (rst) (torque_path && torque_set && gyro_sel == 2'h0) |=> torque_on[0] [*2];
  endproperty
  a_torque: assert property (p_torque) else $error("torque current missing");
  c_coarse: cover property (@(posedge clk) mode == icmc_pkg::ICMC_COARSE && angle_up[0]);
  c_fine: cover property (@(posedge clk) mode == icmc_pkg::ICMC_FINE && torque_on != '0);
  c_disp: cover property (@(posedge clk) mode == icmc_pkg::ICMC_DISPLAY && err_drive[0] != '0);
endmodule : icmc_core

// ==== include/icmc_pkg.sv ====
package icmc_pkg;
  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int RATE_HI_PPS = 6400; // Fast read counter stepping
  localparam int RATE_LO_PPS = 800; // Slow read counter stepping
  localparam int BIT_PPS = 3200; // Computer pulse bit rate
  localparam int RATE_HI_CYC = CLK_HZ / RATE_HI_PPS;
  localparam int RATE_LO_CYC = CLK_HZ / RATE_LO_PPS;
  localparam int BIT_CYC = CLK_HZ / BIT_PPS;
  localparam int DIV_W = 16;
  localparam int TQ_W = 24;

  // ***********************************************
  // Widths
  // ***********************************************
  localparam int AXES = 3;
  localparam int ERR_W = 16; // Holds a full 256-pulse burst with margin
  localparam int RD_W = 16;
  localparam int PEND_W = 8;

  // ***********************************************
  // Register map (word index on the bus)
  // ***********************************************
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_ERR0 = 3'h2;
  localparam logic [2:0] REG_READ0 = 3'h5;
  localparam int CTRL_RATE_LO_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  typedef enum logic [2:0] {
    ICMC_INERTIAL,
    ICMC_FINE,
    ICMC_COARSE,
    ICMC_DISPLAY,
    ICMC_CAGE,
    ICMC_TURN_ON
  } icmc_mode_t;
endpackage : icmc_pkg

// ==== tb/icmc_computer_model.sv ====
`timescale 1ns/10ps
// Guidance computer side: mode discretes, error pulse bursts and gyro torque pulses
module icmc_computer_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  output logic err_cnt_en,
  output logic coarse_align,
  output logic cage_switch,
  output logic cnt_zero,
  output logic torque_en,
  output logic [1:0] gyro_sel,
  output logic gyro_neg,
  output logic torque_set,
  output logic [2:0] cmd_up,
  output logic [2:0] cmd_dn
);
  // Zeroing and coarse align held from power-on; no gyro selected
  initial begin
    {cnt_zero, torque_en, cage_switch, coarse_align, err_cnt_en} = 5'h12;
    {gyro_sel, gyro_neg, torque_set, cmd_up, cmd_dn} = 10'h300;
  end

  // Discretes change together so no illegal mix is seen mid-way
  task automatic set_disc(input logic [4:0] d);
    @(posedge clk);
    {cnt_zero, torque_en, cage_switch, coarse_align, err_cnt_en} <= d;
  endtask : set_disc

  // Signed burst at the fixed bit rate, one pulse per bit period
  task automatic burst(input int ax, input logic neg, input int n);
    repeat (n) begin
      cmd_up[ax] <= !neg;
      cmd_dn[ax] <= neg;
      @(posedge clk);
      cmd_up <= 3'h0;
      cmd_dn <= 3'h0;
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask : burst

  // Enable and select come first, set pulses a clock later; enable stays until current ends
  task automatic torque(input logic [1:0] g, input logic neg, input int n);
    torque_en <= 1'b1;
    gyro_sel <= g;
    gyro_neg <= neg;
    repeat (n) begin
      @(posedge clk);
      torque_set <= 1'b1;
      @(posedge clk);
      torque_set <= 1'b0;
      repeat (BIT_CYC - 2) @(posedge clk);
    end
    repeat (BIT_CYC + 4) @(posedge clk);
    torque_en <= 1'b0;
    gyro_sel <= 2'h3;
    @(posedge clk);
  endtask : torque
endmodule : icmc_computer_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam int RLO = 20;
  localparam int BIT = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic err_cnt_en, coarse_align, cage_switch, cnt_zero, torque_en, gyro_neg, torque_set;
  logic [1:0] gyro_sel;
  logic [2:0] cmd_up, cmd_dn, angle_up, angle_dn, torque_on;
  logic [2:0] gimbal_up = 3'h0, gimbal_dn = 3'h0, avs_address = 3'h0, tq_exp = 3'h0;
  logic [2:0][icmc_pkg::ERR_W-1:0] err_drive;
  logic drive_from_err, torque_path, torque_neg, cage_drive, coarse_relay, no_attitude_lamp;
  icmc_pkg::icmc_mode_t mode;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  int failures = 0, tests_run = 0, cyc = 0, n_up = 0, n_tq = 0, ax, n, k;
  logic [1:0] g;

  always #25 clk = ~clk;

  icmc_core #(.RATE_LO_CYCLES(RLO), .BIT_CYCLES(BIT)) icmc_core_i (.clk(clk), .rst(rst),
    .err_cnt_en(err_cnt_en), .coarse_align(coarse_align), .cage_switch(cage_switch), .cnt_zero(cnt_zero),
    .torque_en(torque_en), .gyro_sel(gyro_sel), .gyro_neg(gyro_neg), .torque_set(torque_set),
    .cmd_up(cmd_up), .cmd_dn(cmd_dn), .gimbal_up(gimbal_up), .gimbal_dn(gimbal_dn), .angle_up(angle_up),
    .angle_dn(angle_dn), .err_drive(err_drive), .drive_from_err(drive_from_err), .torque_path(torque_path),
    .torque_on(torque_on), .torque_neg(torque_neg), .cage_drive(cage_drive), .coarse_relay(coarse_relay),
    .no_attitude_lamp(no_attitude_lamp), .mode(mode), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  icmc_computer_model #(.BIT_CYC(BIT)) icmc_computer_model_i (.clk(clk), .err_cnt_en(err_cnt_en),
    .coarse_align(coarse_align), .cage_switch(cage_switch), .cnt_zero(cnt_zero), .torque_en(torque_en),
    .gyro_sel(gyro_sel), .gyro_neg(gyro_neg), .torque_set(torque_set), .cmd_up(cmd_up), .cmd_dn(cmd_dn));

  // Net angle pulses, torque current cycles on the expected gyro, hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_up <= n_up + $countones(angle_up) - $countones(angle_dn);
    n_tq <= n_tq + int'(torque_on === tq_exp && tq_exp != 3'h0);
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // Mode priority worked out from the discretes {torque, cage, coarse, enable}
  function automatic icmc_pkg::icmc_mode_t exp_mode(input logic [3:0] d);
    if (d[2]) return icmc_pkg::ICMC_CAGE;
    if (d[1] && d[0]) return icmc_pkg::ICMC_COARSE;
    if (d[0]) return icmc_pkg::ICMC_DISPLAY;
    if (d[1]) return icmc_pkg::ICMC_TURN_ON;
    if (d[3]) return icmc_pkg::ICMC_FINE;
    return icmc_pkg::ICMC_INERTIAL;
  endfunction : exp_mode

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low; an idle edge follows release
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic step(input int a, input int cnt);
    repeat (cnt) begin
      gimbal_up[a] <= 1'b1;
      @(posedge clk);
      gimbal_up <= 3'h0;
      @(posedge clk);
    end
  endtask : step

  task automatic step_dn(input int a);
    gimbal_dn[a] <= 1'b1;
    @(posedge clk);
    gimbal_dn <= 3'h0;
    @(posedge clk);
  endtask : step_dn

  task automatic report_and_stop();
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(50162));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(mode, icmc_pkg::ICMC_INERTIAL);
    // Every combination of the mode discretes
    for (int i = 0; i < 16; i++) begin
      icmc_computer_model_i.set_disc({1'b0, i[3:0]});
      repeat (3) @(posedge clk);
      chk(mode, exp_mode(i[3:0]));
      chk({cage_drive, coarse_relay, no_attitude_lamp, torque_path}, {i[2], i[2] | i[1], i[2], i[3] & ~(i[2] | i[1])});
    end
    bus(1'b0, icmc_pkg::REG_STATUS, 32'h0);
    chk(rd[2:0], icmc_pkg::ICMC_CAGE);
    chk(rd[5:3], 3'h4);
    // Coarse align at the slow rate: burst, then fed back gimbal steps
    bus(1'b1, icmc_pkg::REG_CTRL, 32'h1);
    ax = $urandom % 3;
    n = 5 + $urandom % 40;
    icmc_computer_model_i.set_disc(5'b00011);
    repeat (3) @(posedge clk);
    chk(drive_from_err, 1'b1);
    icmc_computer_model_i.burst(ax, 1'b0, n);
    repeat (4) @(posedge clk);
    chk($signed(err_drive[ax]), n);
    k = n_up;
    step(ax, 3);
    chk(n_up - k <= 1, 1);
    // The fast countdown begun at reset must run out before the slow rate applies
    repeat (icmc_pkg::RATE_HI_CYC + 3 * RLO + 10) @(posedge clk);
    chk(n_up - k, 3);
    chk($signed(err_drive[ax]), n - 3);
    // Fast rate: one step per 3125 cycles
    bus(1'b1, icmc_pkg::REG_CTRL, 32'h0);
    k = n_up;
    step(ax, 2);
    repeat (100) @(posedge clk);
    chk(n_up - k <= 1, 1);
    repeat (2 * icmc_pkg::RATE_HI_CYC + 20) @(posedge clk);
    chk(n_up - k, 2);
    chk($signed(err_drive[ax]), n - 5);
    // Display mode from a cleared counter: no feedback, no rate limit
    icmc_computer_model_i.set_disc(5'b00000);
    icmc_computer_model_i.set_disc(5'b00001);
    repeat (3) @(posedge clk);
    icmc_computer_model_i.burst(ax, 1'b1, n);
    k = n_up;
    step(ax, 3);
    repeat (10) @(posedge clk);
    chk(n_up - k, 3);
    k = n_up;
    step_dn(ax);
    repeat (10) @(posedge clk);
    chk(n_up - k, -1);
    chk($signed(err_drive[ax]), -n);
    bus(1'b0, 3'(icmc_pkg::REG_READ0 + ax), 32'h0);
    chk(rd, 32'h7);
    // Fine align: error inhibited, torque current tracks set pulses
    icmc_computer_model_i.set_disc(5'b01000);
    icmc_computer_model_i.burst(ax, 1'b0, 2);
    chk(err_drive[ax], 16'h0000);
    k = n_up;
    step(ax, 1);
    repeat (10) @(posedge clk);
    chk(n_up - k, 1);
    g = 2'($urandom % 3);
    tq_exp <= 3'h1 << g;
    n = 1 + $urandom % 6;
    k = n_tq;
    icmc_computer_model_i.torque(g, 1'b1, n);
    chk(n_tq - k, n * BIT);
    chk(torque_neg, 1'b1);
    repeat (3) @(posedge clk);
    chk(mode, icmc_pkg::ICMC_INERTIAL);
    // Counter zero clears the read counter and blocks steps
    icmc_computer_model_i.set_disc(5'b10000);
    repeat (3) @(posedge clk);
    bus(1'b0, 3'(icmc_pkg::REG_READ0 + ax), 32'h0);
    chk(rd, 32'h0);
    k = n_up;
    step(ax, 2);
    repeat (10) @(posedge clk);
    chk(n_up - k, 0);
    report_and_stop();
  end
endmodule : tb_top
